// ==== inc/mbs_pkg.sv ====
// shared constants and types of the serial meter slave
package mbs_pkg;
    // clock and frame gap timing
    localparam int CLK_PERIOD_NS = 4;
    // 3.5 characters of 11 bits at 4800 bit/s
    localparam int GAP_TIME_NS = 8021000;
    localparam int GAP_CYCLES = (GAP_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int GAP_CNT_W = 22;

    // function codes and exception bytes
    localparam logic [7:0] FN_READ = 8'h03;
    localparam logic [7:0] FN_WRITE = 8'h10;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] ERR_FUNC = 8'h81;
    localparam logic [7:0] ERR_ADDR = 8'h82;
    localparam logic [7:0] ERR_VALUE = 8'h83;

    // frame check
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;

    // register space
    localparam logic [15:0] REG_LO = 16'h0048;
    localparam logic [15:0] REG_HI = 16'h0055;
    localparam logic [15:0] CLR_CH1 = 16'h004b;
    localparam logic [15:0] CLR_CH2 = 16'h0053;
    localparam logic [15:0] CLR_BOTH = 16'h000c;
    localparam logic [15:0] CLR_WORDS = 16'h0002;

    // frame layout
    localparam int BUF_BYTES = 40;
    localparam int MAX_WORDS = 16;
    localparam logic [5:0] READ_REQ_LEN = 6'h08;
    localparam logic [5:0] MIN_FRAME = 6'h04;
    localparam logic [5:0] WR_HDR_CRC = 6'h09;
    localparam logic [5:0] WR_DATA_POS = 6'h07;
    localparam logic [5:0] RD_DATA_POS = 6'h03;
    localparam logic [5:0] RD_OVERHEAD = 6'h05;
    localparam logic [5:0] WR_RESP_LEN = 6'h08;
    localparam logic [5:0] EXC_RESP_LEN = 6'h05;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } mbs_stream_s;

    typedef struct packed {
        logic en;
        logic [15:0] addr;
        logic [15:0] data;
    } mbs_wr_s;

    typedef enum logic [2:0] {
        ST_RECV, ST_CHECK, ST_WRITE, ST_READ, ST_SEND
    } mbs_state_e;

    typedef enum logic [1:0] {
        RESP_READ, RESP_WRITE, RESP_EXC
    } mbs_resp_e;
endpackage

// ==== rtl/mbs_crc16.sv ====
// byte-wise frame check accumulator
`timescale 1ns/10ps
module mbs_crc16 (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // control
    input wire logic clear,
    input wire logic update,
    input wire logic [7:0] data,
    // result
    output logic [15:0] crc
);
    logic [15:0] crc_q;
    logic [15:0] crc_d;

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            if (r[0]) begin
                r = (r >> 1) ^ mbs_pkg::CRC_POLY;
            end else begin
                r = r >> 1;
            end
        end
        return r;
    endfunction

    always_comb begin
        crc_d = crc_q;
        if (clear) begin
            crc_d = mbs_pkg::CRC_INIT;
        end else if (update) begin
            crc_d = crc_step(crc_q, data);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            crc_q <= mbs_pkg::CRC_INIT;
        end else begin
            crc_q <= crc_d;
        end
    end

    assign crc = crc_q;

    a_crc_preset: assert property (@(posedge clock) disable iff (!rst_n)
        clear |=> crc == mbs_pkg::CRC_INIT)
        else $error("crc not preset after clear");
endmodule

// ==== rtl/mbs_gap_timer.sv ====
// line idle timer marking the end of a frame
`timescale 1ns/10ps
module mbs_gap_timer #(
    parameter int unsigned CYCLES = mbs_pkg::GAP_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // line activity and frame end
    input wire logic activity,
    output logic frame_end
);
    logic [mbs_pkg::GAP_CNT_W-1:0] cnt_q, cnt_d;
    logic armed_q, armed_d;
    logic end_q, end_d;

    always_comb begin
        cnt_d = cnt_q;
        armed_d = armed_q;
        end_d = 1'b0;
        if (activity) begin
            cnt_d = '0;
            armed_d = 1'b1;
        end else if (armed_q) begin
            if (cnt_q == mbs_pkg::GAP_CNT_W'(CYCLES - 1)) begin
                end_d = 1'b1;
                armed_d = 1'b0;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            armed_q <= 1'b0;
            end_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            armed_q <= armed_d;
            end_q <= end_d;
        end
    end

    assign frame_end = end_q;

    a_gap_single: assert property (@(posedge clock) disable iff (!rst_n)
        frame_end |=> !frame_end)
        else $error("frame end longer than one cycle");
endmodule

// ==== rtl/mbs_slave.sv ====
// request interpreter of the meter's serial slave
// Function
// - answer read requests of function 03 with the asked registers
// - read reply is address, function, byte count, words, check
// - function 10 writes a run of registers from the start address
// - write reply echoes address, function, start, count, new check
// - each register is two bytes, high byte first both ways
// - exception is address, function with top bit, code, check
// - unsupported function gives error code 81
// - registers outside the usable range give error code 82
// - out of range written value gives error code 83
// - two zero words at 004b clear the first channel energy
// - two zero words at 0053 clear the second channel energy
// - two zero words at 000c clear both channels' energy
// - fourteen words from 0048 return byte count 28 and all words
// - check is crc16, preset ones, poly a001, low byte sent first
// - respond only to own address, else stay silent
// - characters are start, eight data, optional parity, stop bits
`timescale 1ns/10ps
module mbs_slave #(
    parameter int unsigned GAP_CYCLES = mbs_pkg::GAP_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // configuration
    input wire logic [7:0] own_addr,
    // received characters from the line receiver
    input wire mbs_pkg::mbs_stream_s rx,
    input wire logic rx_err,
    // characters to the line transmitter
    output mbs_pkg::mbs_stream_s tx,
    input wire logic tx_ready,
    // register read port, data valid in the same cycle as the request
    output logic rd_req,
    output logic [15:0] rd_addr,
    input wire logic [15:0] rd_data,
    // register write port
    output mbs_pkg::mbs_wr_s wr,
    // energy clear pulses
    output logic clr_ch1,
    output logic clr_ch2
);
    logic [1:0] rst_sync_q;
    logic rst_s_n;

    mbs_pkg::mbs_state_e state_q, state_d;
    mbs_pkg::mbs_resp_e kind_q, kind_d;
    logic [7:0] buf_q [mbs_pkg::BUF_BYTES];
    logic [7:0] buf_d [mbs_pkg::BUF_BYTES];
    logic [15:0] rdat_q [mbs_pkg::MAX_WORDS];
    logic [15:0] rdat_d [mbs_pkg::MAX_WORDS];
    logic [5:0] len_q, len_d;
    logic [5:0] idx_q, idx_d;
    logic ovf_q, ovf_d;
    logic bad_q, bad_d;
    logic [7:0] func_q, func_d;
    logic [7:0] err_q, err_d;
    logic [15:0] start_q, start_d;
    logic [15:0] cnt_q, cnt_d;
    mbs_pkg::mbs_stream_s tx_q, tx_d;
    logic rd_req_q, rd_req_d;
    logic [15:0] rd_addr_q, rd_addr_d;
    mbs_pkg::mbs_wr_s wr_q, wr_d;
    logic clr1_q, clr1_d;
    logic clr2_q, clr2_d;

    logic frame_end;
    logic [15:0] rx_crc;
    logic [15:0] tx_crc;
    logic tx_free;
    logic tx_load;
    logic [7:0] tx_byte;
    logic [5:0] tx_len;
    logic [5:0] rk;
    logic [15:0] f_start;
    logic [15:0] f_cnt;
    logic frame_ok;
    logic addr_ok;
    logic val_bad;
    logic [5:0] wi;

    // asynchronous assert, synchronous release
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_s_n = rst_sync_q[1];

    function automatic logic in_range(input logic [15:0] s,
                                      input logic [15:0] n);
        logic [16:0] last;
        last = {1'b0, s} + {1'b0, n} - 17'h00001;
        return (n != 16'h0000) && (n <= 16'(mbs_pkg::MAX_WORDS))
            && (s >= mbs_pkg::REG_LO) && (last <= {1'b0, mbs_pkg::REG_HI});
    endfunction

    function automatic logic is_clear_loc(input logic [15:0] a);
        return (a == mbs_pkg::CLR_CH1) || (a == mbs_pkg::CLR_CH1 + 16'h1)
            || (a == mbs_pkg::CLR_CH2) || (a == mbs_pkg::CLR_CH2 + 16'h1)
            || (a == mbs_pkg::CLR_BOTH) || (a == mbs_pkg::CLR_BOTH + 16'h1);
    endfunction

    mbs_gap_timer #(.CYCLES(GAP_CYCLES)) u_gap (
        .clock(clock),
        .rst_n(rst_s_n),
        .activity(rx.valid),
        .frame_end(frame_end)
    );

    // check of the received frame, residue is zero when intact
    mbs_crc16 u_rx_crc (
        .clock(clock),
        .rst_n(rst_s_n),
        .clear(state_q == mbs_pkg::ST_CHECK),
        .update(state_q == mbs_pkg::ST_RECV && rx.valid),
        .data(rx.data),
        .crc(rx_crc)
    );

    mbs_crc16 u_tx_crc (
        .clock(clock),
        .rst_n(rst_s_n),
        .clear(state_q == mbs_pkg::ST_CHECK),
        .update(tx_load),
        .data(tx_byte),
        .crc(tx_crc)
    );

    // request fields, words high byte first
    assign f_start = {buf_q[2], buf_q[3]};
    assign f_cnt = {buf_q[4], buf_q[5]};
    // parity or framing errors spoil the whole frame
    assign frame_ok = !ovf_q && !bad_q && !rx_err
        && len_q >= mbs_pkg::MIN_FRAME && rx_crc == 16'h0000;
    assign addr_ok = buf_q[0] == own_addr;

    always_comb begin
        logic [15:0] a;
        logic [15:0] w;
        a = 16'h0000;
        w = 16'h0000;
        val_bad = 1'b0;
        for (int i = 0; i < mbs_pkg::MAX_WORDS; i++) begin
            a = f_start + 16'(i);
            w = {buf_q[7 + 2 * i], buf_q[8 + 2 * i]};
            if (16'(i) < f_cnt && is_clear_loc(a) && w != 16'h0000) begin
                val_bad = 1'b1;
            end
        end
    end

    // reply length and byte selection
    always_comb begin
        case (kind_q)
            mbs_pkg::RESP_READ: tx_len = mbs_pkg::RD_OVERHEAD
                + {cnt_q[4:0], 1'b0};
            mbs_pkg::RESP_WRITE: tx_len = mbs_pkg::WR_RESP_LEN;
            default: tx_len = mbs_pkg::EXC_RESP_LEN;
        endcase
    end

    assign rk = idx_q - mbs_pkg::RD_DATA_POS;
    assign tx_free = !tx_q.valid || tx_ready;
    // the check bytes themselves must not feed the running check
    assign tx_load = state_q == mbs_pkg::ST_SEND && tx_free
        && idx_q < tx_len - 6'h02;

    always_comb begin
        tx_byte = 8'h00;
        if (idx_q == tx_len - 6'h02) begin
            tx_byte = tx_crc[7:0];
        end else if (idx_q == tx_len - 6'h01) begin
            tx_byte = tx_crc[15:8];
        end else if (idx_q == 6'h00) begin
            tx_byte = buf_q[0];
        end else begin
            case (kind_q)
                mbs_pkg::RESP_READ: begin
                    if (idx_q == 6'h01) begin
                        tx_byte = func_q;
                    end else if (idx_q == 6'h02) begin
                        tx_byte = {cnt_q[6:0], 1'b0};
                    end else if (!rk[0]) begin
                        tx_byte = rdat_q[rk[4:1]][15:8];
                    end else begin
                        tx_byte = rdat_q[rk[4:1]][7:0];
                    end
                end
                mbs_pkg::RESP_WRITE: begin
                    case (idx_q)
                        6'h01: tx_byte = func_q;
                        6'h02: tx_byte = start_q[15:8];
                        6'h03: tx_byte = start_q[7:0];
                        6'h04: tx_byte = cnt_q[15:8];
                        default: tx_byte = cnt_q[7:0];
                    endcase
                end
                default: begin
                    if (idx_q == 6'h01) begin
                        tx_byte = func_q | mbs_pkg::EXC_FLAG;
                    end else begin
                        tx_byte = err_q;
                    end
                end
            endcase
        end
    end

    assign wi = mbs_pkg::WR_DATA_POS + {idx_q[4:0], 1'b0};

    always_comb begin
        state_d = state_q;
        kind_d = kind_q;
        buf_d = buf_q;
        rdat_d = rdat_q;
        len_d = len_q;
        idx_d = idx_q;
        ovf_d = ovf_q;
        bad_d = bad_q;
        func_d = func_q;
        err_d = err_q;
        start_d = start_q;
        cnt_d = cnt_q;
        tx_d = tx_q;
        rd_req_d = 1'b0;
        rd_addr_d = rd_addr_q;
        wr_d = wr_q;
        wr_d.en = 1'b0;
        clr1_d = 1'b0;
        clr2_d = 1'b0;
        case (state_q)
            mbs_pkg::ST_RECV: begin
                // overlong frames are flagged and later dropped
                if (rx.valid) begin
                    if (len_q < 6'(mbs_pkg::BUF_BYTES)) begin
                        buf_d[len_q] = rx.data;
                        len_d = len_q + 6'h01;
                    end else begin
                        ovf_d = 1'b1;
                    end
                    bad_d = bad_q | rx_err;
                end
                if (frame_end) begin
                    state_d = mbs_pkg::ST_CHECK;
                end
            end
            mbs_pkg::ST_CHECK: begin
                len_d = 6'h00;
                ovf_d = 1'b0;
                bad_d = 1'b0;
                idx_d = 6'h00;
                func_d = buf_q[1];
                start_d = f_start;
                cnt_d = f_cnt;
                state_d = mbs_pkg::ST_SEND;
                kind_d = mbs_pkg::RESP_EXC;
                if (!frame_ok || !addr_ok) begin
                    state_d = mbs_pkg::ST_RECV;
                end else if (buf_q[1] == mbs_pkg::FN_READ) begin
                    if (len_q != mbs_pkg::READ_REQ_LEN) begin
                        state_d = mbs_pkg::ST_RECV;
                    end else if (!in_range(f_start, f_cnt)) begin
                        err_d = mbs_pkg::ERR_ADDR;
                    end else begin
                        state_d = mbs_pkg::ST_READ;
                    end
                end else if (buf_q[1] == mbs_pkg::FN_WRITE) begin
                    if (!in_range(f_start, f_cnt) && !(f_start ==
                        mbs_pkg::CLR_BOTH && f_cnt == mbs_pkg::CLR_WORDS))
                    begin
                        err_d = mbs_pkg::ERR_ADDR;
                    end else if (buf_q[6] != {f_cnt[6:0], 1'b0}
                        || len_q != mbs_pkg::WR_HDR_CRC + buf_q[6][5:0]
                        || val_bad) begin
                        err_d = mbs_pkg::ERR_VALUE;
                    end else begin
                        state_d = mbs_pkg::ST_WRITE;
                    end
                end else begin
                    err_d = mbs_pkg::ERR_FUNC;
                end
            end
            mbs_pkg::ST_WRITE: begin
                if (idx_q < cnt_q[5:0]) begin
                    wr_d.en = 1'b1;
                    wr_d.addr = start_q + {10'h000, idx_q};
                    wr_d.data = {buf_q[wi], buf_q[wi + 6'h01]};
                    idx_d = idx_q + 6'h01;
                end else begin
                    // checked zero data already, so these are clears
                    if (cnt_q == mbs_pkg::CLR_WORDS) begin
                        clr1_d = start_q == mbs_pkg::CLR_CH1
                            || start_q == mbs_pkg::CLR_BOTH;
                        clr2_d = start_q == mbs_pkg::CLR_CH2
                            || start_q == mbs_pkg::CLR_BOTH;
                    end
                    kind_d = mbs_pkg::RESP_WRITE;
                    idx_d = 6'h00;
                    state_d = mbs_pkg::ST_SEND;
                end
            end
            mbs_pkg::ST_READ: begin
                if (rd_req_q) begin
                    rdat_d[idx_q[3:0]] = rd_data;
                    idx_d = idx_q + 6'h01;
                    if (idx_q + 6'h01 == cnt_q[5:0]) begin
                        kind_d = mbs_pkg::RESP_READ;
                        idx_d = 6'h00;
                        state_d = mbs_pkg::ST_SEND;
                    end
                end else begin
                    rd_req_d = 1'b1;
                    rd_addr_d = start_q + {10'h000, idx_q};
                end
            end
            mbs_pkg::ST_SEND: begin
                if (tx_free) begin
                    if (idx_q < tx_len) begin
                        tx_d.valid = 1'b1;
                        tx_d.data = tx_byte;
                        idx_d = idx_q + 6'h01;
                    end else begin
                        tx_d.valid = 1'b0;
                        state_d = mbs_pkg::ST_RECV;
                    end
                end
            end
            default: state_d = mbs_pkg::ST_RECV;
        endcase
    end

    always_ff @(posedge clock or negedge rst_s_n) begin
        if (!rst_s_n) begin
            state_q <= mbs_pkg::ST_RECV;
            kind_q <= mbs_pkg::RESP_EXC;
            for (int i = 0; i < mbs_pkg::BUF_BYTES; i++) begin
                buf_q[i] <= 8'h00;
            end
            for (int i = 0; i < mbs_pkg::MAX_WORDS; i++) begin
                rdat_q[i] <= 16'h0000;
            end
            len_q <= 6'h00;
            idx_q <= 6'h00;
            ovf_q <= 1'b0;
            bad_q <= 1'b0;
            func_q <= 8'h00;
            err_q <= 8'h00;
            start_q <= 16'h0000;
            cnt_q <= 16'h0000;
            tx_q <= '0;
            rd_req_q <= 1'b0;
            rd_addr_q <= 16'h0000;
            wr_q <= '0;
            clr1_q <= 1'b0;
            clr2_q <= 1'b0;
        end else begin
            state_q <= state_d;
            kind_q <= kind_d;
            buf_q <= buf_d;
            rdat_q <= rdat_d;
            len_q <= len_d;
            idx_q <= idx_d;
            ovf_q <= ovf_d;
            bad_q <= bad_d;
            func_q <= func_d;
            err_q <= err_d;
            start_q <= start_d;
            cnt_q <= cnt_d;
            tx_q <= tx_d;
            rd_req_q <= rd_req_d;
            rd_addr_q <= rd_addr_d;
            wr_q <= wr_d;
            clr1_q <= clr1_d;
            clr2_q <= clr2_d;
        end
    end

    assign tx = tx_q;
    assign rd_req = rd_req_q;
    assign rd_addr = rd_addr_q;
    assign wr = wr_q;
    assign clr_ch1 = clr1_q;
    assign clr_ch2 = clr2_q;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_s_n);

    a_read_bytecount: assert property (
        state_q == mbs_pkg::ST_SEND && kind_q == mbs_pkg::RESP_READ
        && tx_load && idx_q == 6'h02 |=> tx.data == {cnt_q[6:0], 1'b0})
        else $error("read byte count not twice the word count");
    a_exc_topbit: assert property (
        kind_q == mbs_pkg::RESP_EXC && tx_load && idx_q == 6'h01
        |=> tx.valid && tx.data[7])
        else $error("exception function byte lacks top bit");
    a_write_echo: assert property (
        kind_q == mbs_pkg::RESP_WRITE && tx_load && idx_q == 6'h04
        |=> tx.data == cnt_q[15:8])
        else $error("write reply does not echo the count");
    a_silent_foreign: assert property (
        state_q == mbs_pkg::ST_CHECK && !addr_ok
        |=> state_q == mbs_pkg::ST_RECV && !tx.valid)
        else $error("reply to a foreign address");
    a_drop_badcrc: assert property (
        state_q == mbs_pkg::ST_CHECK && rx_crc != 16'h0000
        |=> state_q == mbs_pkg::ST_RECV ##1 !tx.valid)
        else $error("frame with bad check not dropped");
    a_read_strobe: assert property (
        rd_req |=> !rd_req ##1 (rd_req || state_q == mbs_pkg::ST_SEND))
        else $error("read strobe pacing broken");
    a_clear_pulse: assert property (
        clr_ch1 |-> $past(state_q) == mbs_pkg::ST_WRITE && !$past(clr_ch1)
        ##1 state_q == mbs_pkg::ST_SEND)
        else $error("energy clear pulse malformed");
    a_tx_hold: assert property (
        tx.valid && !tx_ready |=> tx.valid && $stable(tx.data))
        else $error("transmit byte changed while stalled");
endmodule

// ==== tb/mbs_host_model.sv ====
// host side of the serial link: frames out, replies in
`timescale 1ns/10ps
module mbs_host_model (
    // clock
    input wire logic clock,
    // link to the slave
    output mbs_pkg::mbs_stream_s rx,
    input wire mbs_pkg::mbs_stream_s tx,
    output logic tx_ready,
    // slow acceptance when high
    input wire logic stall
);
    logic [7:0] got[$];
    initial begin
        rx = '0;
        tx_ready = 1'b0;
    end
    always @(posedge clock) begin
        tx_ready <= stall ? 1'($urandom_range(1)) : 1'b1;
        if (tx.valid && tx_ready)
            got.push_back(tx.data);
    end
    // data line shows junk between characters, never the last value
    task automatic send(input logic [7:0] q[$]);
        foreach (q[i]) begin
            @(posedge clock);
            rx <= {1'b1, q[i]};
            @(posedge clock);
            rx <= {1'b0, ~q[i]};
        end
    endtask
endmodule

// ==== tb/mbs_slave_test.sv ====
// self-checking bench of the serial meter slave
`timescale 1ns/10ps
module mbs_slave_test;
    localparam int GAP = 20;
    logic clock, rst_n, rx_err, stall, tx_ready, rd_req, clr_ch1, clr_ch2;
    logic [7:0] own_addr, salt;
    logic [15:0] rd_data, rd_addr, s;
    mbs_pkg::mbs_stream_s rx, tx;
    mbs_pkg::mbs_wr_s wr;
    int error_cnt = 0, n_compared = 0, cyc = 0, n1 = 0, n2 = 0;
    logic [31:0] wlog[$];
    logic [7:0] f[$], e[$];
    logic [7:0] fc[4] = '{8'h01, 8'h05, 8'h04, 8'h06};

    mbs_slave #(.GAP_CYCLES(GAP)) dut (.clock(clock), .rst_n(rst_n),
        .own_addr(own_addr), .rx(rx), .rx_err(rx_err), .tx(tx),
        .tx_ready(tx_ready), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_data(rd_data), .wr(wr), .clr_ch1(clr_ch1), .clr_ch2(clr_ch2));
    mbs_host_model host (.clock(clock), .rx(rx), .tx(tx),
        .tx_ready(tx_ready), .stall(stall));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // contents tied to the address so misordered words show up
    assign rd_data = {rd_addr[7:0] ^ salt, ~rd_addr[7:0]};

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (wr.en)
            wlog.push_back({wr.addr, wr.data});
        n1 <= n1 + int'(clr_ch1);
        n2 <= n2 + int'(clr_ch2);
        if (cyc == 40000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    function automatic logic [15:0] crc(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[i]) begin
            c ^= {8'h00, b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            error_cnt++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
        end
    endtask

    // empty x means no reply may appear
    task automatic xact(input logic [7:0] q[$], input logic [7:0] x[$],
        input bit bad);
        logic [15:0] c;
        c = crc(q) ^ {15'h0000, bad};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        if (x.size() > 0) begin
            c = crc(x);
            x.push_back(c[7:0]);
            x.push_back(c[15:8]);
        end
        host.got.delete();
        host.send(q);
        for (int i = 0; i < 3000 && host.got.size() < x.size(); i++)
            @(posedge clock);
        repeat (GAP + 80) @(posedge clock);
        chk(32'(host.got.size()), 32'(x.size()));
        if (host.got.size() == x.size())
            foreach (x[i]) chk(32'(host.got[i]), 32'(x[i]));
    endtask

    task automatic rdt(input logic [15:0] a, input logic [7:0] n);
        f = '{own_addr, 8'h03, a[15:8], a[7:0], 8'h00, n};
        e = '{own_addr, 8'h03, n << 1};
        for (logic [15:0] k = a; k < a + 16'(n); k++) begin
            e.push_back(k[7:0] ^ salt);
            e.push_back(~k[7:0]);
        end
        xact(f, e, 1'b0);
    endtask

    // code 0 expects a normal reply and every word on the write port
    task automatic wrt(input logic [15:0] a, input logic [7:0] n,
        input bit z, input logic [7:0] code);
        logic [15:0] w[$];
        f = '{own_addr, 8'h10, a[15:8], a[7:0], 8'h00, n, n << 1};
        for (int i = 0; i < n; i++) begin
            w.push_back(z ? 16'h0000 : 16'($urandom_range(16'hffff, 1)));
            f.push_back(w[i][15:8]);
            f.push_back(w[i][7:0]);
        end
        e = f[0:5];
        if (code != 8'h00)
            e = '{own_addr, 8'h90, code};
        wlog.delete();
        xact(f, e, 1'b0);
        chk(32'(wlog.size()), code != 8'h00 ? 32'h0 : 32'(n));
        if (code == 8'h00)
            foreach (w[i]) chk(wlog[i], {a + 16'(i), w[i]});
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        rx_err = 1'b0;
        stall = 1'b1;
        own_addr = 8'h01;
        salt = 8'h00;
        void'($urandom(54));
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        salt <= 8'($urandom);
        own_addr <= 8'($urandom_range(8'hf7, 8'h01));
        repeat (4) @(posedge clock);
        rdt(16'h0048, 8'd14);
        repeat (6) begin
            s = 16'h0048 + 16'($urandom_range(13));
            rdt(s, 8'(1 + $urandom_range(16'h0055 - s)));
        end
        $display("test read done");
        repeat (4) begin
            s = 16'h004d + 16'($urandom_range(5));
            wrt(s, 8'(1 + $urandom_range(16'h0052 - s)), 1'b0, 8'h00);
        end
        wrt(16'h004b, 8'd2, 1'b0, 8'h83);
        wrt(16'h0056, 8'd1, 1'b1, 8'h82);
        $display("test write done");
        foreach (fc[i]) begin
            f = '{own_addr, fc[i], 8'h00, 8'h48, 8'h00, 8'h01};
            e = '{own_addr, fc[i] | 8'h80, 8'h81};
            xact(f, e, 1'b0);
        end
        f = '{own_addr, 8'h03, 8'h00, 8'h48, 8'h00, 8'h0f};
        e = '{own_addr, 8'h83, 8'h82};
        xact(f, e, 1'b0);
        f[3] = 8'h47;
        f[5] = 8'h01;
        xact(f, e, 1'b0);
        $display("test exception done");
        stall <= 1'b0;
        f[0] = own_addr + 8'h01;
        e.delete();
        xact(f, e, 1'b0);
        f = '{own_addr, 8'h03, 8'h00, 8'h48, 8'h00, 8'h01};
        xact(f, e, 1'b1);
        rx_err <= 1'b1;
        xact(f, e, 1'b0);
        rx_err <= 1'b0;
        $display("test silent done");
        wrt(16'h004b, 8'd2, 1'b1, 8'h00);
        chk({16'(n1), 16'(n2)}, 32'h0001_0000);
        wrt(16'h0053, 8'd2, 1'b1, 8'h00);
        chk({16'(n1), 16'(n2)}, 32'h0001_0001);
        wrt(16'h000c, 8'd2, 1'b1, 8'h00);
        chk({16'(n1), 16'(n2)}, 32'h0002_0002);
        $display("test clear done");
        tally_and_finish();
    end
endmodule
